// [hw/opd_pkg.sv]
/*
  Package for the operand decoder: opcodes, field widths, byte counts,
  flag-effect codes and decoder states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package opd_pkg;
  // Field widths, pair masks and working-register page
  localparam int BIT_W = 3;
  localparam int EXT_W = 12;
  localparam int REG_W = 8;
  localparam int ADDR_W = 16;
  localparam logic [7:0] PAIR_MASK = 8'h_FE;
  localparam logic [3:0] WPAIR_MASK = 4'h_E;
  localparam logic [7:0] WREG_PAGE = 8'h_E0;
  // Opcodes handled here
  localparam logic [7:0] OP_BYTE_MULTIPLY_OP = 8'h_F4;
  localparam logic [7:0] OP_PMOVE_TO_R = 8'h_C3;
  localparam logic [7:0] OP_PMOVE_TO_M = 8'h_D3;
  localparam logic [7:0] OP_DMOVE_TO_R = 8'h_83;
  localparam logic [7:0] OP_DMOVE_TO_M = 8'h_93;
  localparam logic [7:0] OP_TRAP = 8'h_F2;
  localparam logic [7:0] OP_NOP = 8'h_0F;
  localparam logic [7:0] OP_LDX_R_ER = 8'h_84;
  localparam logic [7:0] OP_LDX_ER_ER = 8'h_E8;
  localparam logic [7:0] OP_LDX_ER_IM = 8'h_E9;
  localparam logic [7:0] OP_LDX_R_XRR = 8'h_88;
  localparam logic [7:0] OP_LEA_R = 8'h_98;
  localparam logic [7:0] OP_TM_R_IM = 8'h_76;
  // Stack adjustments for trap entry, then stack pointer and PC reset values
  localparam logic [15:0] TRAP_PC_DEC = 16'h_0002;
  localparam logic [15:0] TRAP_FLAG_DEC = 16'h_0001;
  localparam logic [15:0] RESET_SP = 16'h_0000;
  localparam logic [15:0] RESET_PC = 16'h_0000;
  // Instruction lengths in bytes
  localparam logic [2:0] LEN_1 = 3'h_1;
  localparam logic [2:0] LEN_2 = 3'h_2;
  localparam logic [2:0] LEN_3 = 3'h_3;
  localparam logic [2:0] LEN_4 = 3'h_4;
  // Flag effect codes
  typedef enum logic [2:0] {
    FX_KEEP = 3'h_0, FX_RESULT = 3'h_1, FX_UNDEF = 3'h_2,
    FX_CLR = 3'h_3, FX_SET = 3'h_4
  } opd_fx_t;
  // Decoder states
  typedef enum logic [3:0] {
    ST_OPC = 4'b_0001, ST_OPND = 4'b_0010, ST_EXEC = 4'b_0100,
    ST_TRAP2 = 4'b_1000
  } opd_state_t;
endpackage : opd_pkg

// [hw/opd_decoder.sv]
/*
  Operand decoder: collects instruction bytes from program memory,
  sizes and interprets operand fields, and carries out multiply,
  auto-incrementing block moves and trap entry.
  Assumes program memory presents one byte with a valid strobe on
  clk_sys, and the datapath supplies register and flag values.
*/
// Notes on behaviour
// - Bit operand is a 3-bit position 0..7 within a byte.
// - Extended register operand is a 12-bit file address 000..FFF.
// - Register, indirect and vector operands are 8-bit addresses.
// - Register pairs are even; working pairs are even, 0..14.
// - Relative offset is signed byte added to next-instruction address.
// - Indexed address adds signed index byte to register or pair.
// - Direct address operand is a full 16-bit address.
// - Immediate operand is one literal byte from the stream.
// - Polarity operand is one bit selecting zero or one.
// - Multiply high byte by low byte of pair, store product, flags kept.
// - Program-memory block move increments both pointers by one.
// - Data-memory block move increments both pointers, flags kept.
// - Trap pushes PC at SP-2, then flags at SP-3 while loading PC.
// - Flag codes: result, unchanged, undefined, forced zero or one.
`timescale 1ns/100ps
module opd_decoder (
  input wire logic clk_sys, // System clock, 200 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire logic fetch_valid, // Fetched byte is present
  input wire logic [7:0] fetch_byte, // Byte from program memory
  input wire logic [15:0] program_counter, // Address of current opcode
  input wire logic [15:0] stack_pointer, // Current stack pointer
  input wire logic [15:0] pair_value, // Value of addressed pair
  input wire logic [7:0] index_base, // Value of base register
  input wire logic [7:0] wreg_value, // Working register pointer value
  input wire logic [7:0] flags_in, // Current flags
  input wire logic [15:0] vector_data, // Word read at vector address
  output logic busy, // Decoder is mid-instruction
  output logic [2:0] instr_len, // Bytes in current instruction
  output logic [7:0] opcode, // Latched opcode
  output logic [2:0] bit_sel, // Bit position operand
  output logic polarity, // Polarity operand
  output logic [11:0] extended_reg_operand, // Extended register address
  output logic [7:0] reg_addr, // 8-bit register address
  output logic [7:0] pair_addr, // Even pair address
  output logic [3:0] wpair_sel, // Even working pair number
  output logic [7:0] immediate_operand, // Literal byte
  output logic [15:0] direct_addr_operand, // 16-bit address
  output logic [15:0] relative_target, // Branch target
  output logic [15:0] indexed_addr, // Indexed effective address
  output logic [2:0] flag_fx, // Flag effect code for flag C
  output logic wr_pair_en, // Write pair_wdata to pair
  output logic [15:0] pair_wdata, // Data for pair write
  output logic wr_wreg_en, // Write wreg_wdata to working register
  output logic [7:0] wreg_wdata, // Incremented working pointer
  output logic push_en, // Push to stack
  output logic [15:0] push_addr, // Stack address of push
  output logic [15:0] push_data, // Data pushed
  output logic push_word, // Push is a 16-bit word
  output logic sp_wr_en, // Update stack pointer
  output logic [15:0] sp_wdata, // New stack pointer
  output logic pc_load_en, // Load program counter
  output logic [15:0] pc_wdata // New program counter
);

  // All decoder state lives in one packed record. The three operand
  // bytes are kept separately, so every field view below is built from
  // flip-flops and datapath inputs and never from the live fetch bus.
  // The write-back pulses (wr_pair, wr_wreg, push, sp_wr, pc_ld) are
  // cleared by default on every cycle in the next-state logic. Each
  // one lasts one clock unless the next state sets it again, as the
  // trap does with push and sp_wr. The data that goes with a pulse holds
  // its value until the next pulse of the same kind, so the datapath may
  // sample it a cycle late, except the first push and sp_wr of a trap.
  // The stored stack pointer value (sp_d) is reused by the second
  // half of the trap. That saves a second read of stack_pointer in a
  // cycle in which the datapath may already be writing it.
  typedef struct packed {
    opd_pkg::opd_state_t st;
    logic [2:0] len;
    logic [2:0] cnt;
    logic [7:0] opc;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic wr_pair;
    logic [15:0] pair_d;
    logic wr_wreg;
    logic [7:0] wreg_d;
    logic push;
    logic [15:0] push_a;
    logic [15:0] push_d;
    logic push_w;
    logic sp_wr;
    logic [15:0] sp_d;
    logic pc_ld;
    logic [15:0] pc_d;
  } opd_state_s_t;

  opd_state_s_t cur_ff;
  opd_state_s_t nxt_cur;

  // The fetch unit relies on this count to advance the program
  // counter. An opcode outside the handled set is treated as a single
  // byte. That keeps the decoder moving, but the datapath must trap
  // such opcodes itself, because their operands would otherwise be
  // read as the next opcode.
  // The count includes the opcode byte, so the operand state collects
  // len - 1 further bytes before execution starts.
  // Byte count for an opcode; unknown opcodes take one byte
  function automatic logic [2:0] opd_len(input logic [7:0] op);
    logic [2:0] l;
    l = opd_pkg::LEN_1;
    if (op == opd_pkg::OP_BYTE_MULTIPLY_OP || op == opd_pkg::OP_TRAP) begin
      l = opd_pkg::LEN_2;
    end else if (op == opd_pkg::OP_PMOVE_TO_R ||
                 op == opd_pkg::OP_PMOVE_TO_M ||
                 op == opd_pkg::OP_DMOVE_TO_R ||
                 op == opd_pkg::OP_DMOVE_TO_M) begin
      l = opd_pkg::LEN_2;
    end else if (op == opd_pkg::OP_LDX_R_ER ||
                 op == opd_pkg::OP_LDX_R_XRR ||
                 op == opd_pkg::OP_LEA_R ||
                 op == opd_pkg::OP_TM_R_IM) begin
      l = opd_pkg::LEN_3;
    end else if (op == opd_pkg::OP_LDX_ER_ER ||
                 op == opd_pkg::OP_LDX_ER_IM) begin
      l = opd_pkg::LEN_4;
    end
    return l;
  endfunction : opd_len

  // Shared by the relative and the indexed views. The sum wraps
  // modulo 64K, as the address space does, so a branch near the top
  // of memory reaches the bottom without any special case.
  // Sign-extend a byte and add it to a 16-bit base
  function automatic logic [15:0] opd_sadd(input logic [15:0] base,
                                           input logic [7:0] off);
    return base + {{8{off[7]}}, off};
  endfunction : opd_sadd

  function automatic logic is_block_move(input logic [7:0] op);
    return op == opd_pkg::OP_PMOVE_TO_R || op == opd_pkg::OP_PMOVE_TO_M ||
           op == opd_pkg::OP_DMOVE_TO_R || op == opd_pkg::OP_DMOVE_TO_M;
  endfunction : is_block_move

  // The four states run in this order:
  //   opcode wait -> operand bytes -> execute -> (trap second half)
  // A byte is consumed only on a cycle with fetch_valid high in the
  // first two states. The last two states ignore the fetch bus, so
  // program memory must not present the next opcode before busy
  // falls. An early byte in those states would be silently lost.
  // The operand bytes are cleared when an opcode is taken, so the
  // field views of a short instruction never show bytes left over
  // from a longer one.
  // Next-state logic: fetch, collect operands, then execute
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.wr_pair = 1'b0;
    nxt_cur.wr_wreg = 1'b0;
    nxt_cur.push = 1'b0;
    nxt_cur.sp_wr = 1'b0;
    nxt_cur.pc_ld = 1'b0;
    case (cur_ff.st)
      opd_pkg::ST_OPC: begin
        if (fetch_valid) begin
          nxt_cur.opc = fetch_byte;
          nxt_cur.len = opd_len(fetch_byte);
          nxt_cur.cnt = 3'h_1;
          nxt_cur.b1 = 8'h_00;
          nxt_cur.b2 = 8'h_00;
          nxt_cur.b3 = 8'h_00;
          nxt_cur.st = (opd_len(fetch_byte) == opd_pkg::LEN_1) ?
                       opd_pkg::ST_EXEC : opd_pkg::ST_OPND;
        end
      end
      opd_pkg::ST_OPND: begin
        if (fetch_valid) begin
          if (cur_ff.cnt == 3'h_1) begin
            nxt_cur.b1 = fetch_byte;
          end else if (cur_ff.cnt == 3'h_2) begin
            nxt_cur.b2 = fetch_byte;
          end else begin
            nxt_cur.b3 = fetch_byte;
          end
          nxt_cur.cnt = cur_ff.cnt + 3'h_1;
          if (cur_ff.cnt + 3'h_1 == cur_ff.len) begin
            nxt_cur.st = opd_pkg::ST_EXEC;
          end
        end
      end
      opd_pkg::ST_EXEC: begin
        nxt_cur.st = opd_pkg::ST_OPC;
        if (cur_ff.opc == opd_pkg::OP_BYTE_MULTIPLY_OP) begin
          // Product of the two halves; no flag write is issued
          nxt_cur.wr_pair = 1'b1;
          // Widen both halves first, so the product keeps all 16 bits
          nxt_cur.pair_d = 16'(pair_value[15:8]) *
                           16'(pair_value[7:0]);
        end else if (is_block_move(cur_ff.opc)) begin
          // Transfer itself is the datapath's; both pointers step by one
          nxt_cur.wr_wreg = 1'b1;
          nxt_cur.wreg_d = wreg_value + 8'h_01;
          nxt_cur.wr_pair = 1'b1;
          nxt_cur.pair_d = pair_value + 16'h_0001;
        end else if (cur_ff.opc == opd_pkg::OP_TRAP) begin
          // Program counter pushed first, at the lower two bytes
          nxt_cur.push = 1'b1;
          nxt_cur.push_w = 1'b1;
          nxt_cur.push_a = stack_pointer - opd_pkg::TRAP_PC_DEC;
          nxt_cur.push_d = program_counter + 16'(cur_ff.len);
          nxt_cur.sp_wr = 1'b1;
          nxt_cur.sp_d = stack_pointer - opd_pkg::TRAP_PC_DEC;
          nxt_cur.st = opd_pkg::ST_TRAP2;
        end
      end
      opd_pkg::ST_TRAP2: begin
        // Flags pushed below the saved PC; the vector is taken in the same cycle
        nxt_cur.push = 1'b1;
        nxt_cur.push_w = 1'b0;
        nxt_cur.push_a = cur_ff.sp_d - opd_pkg::TRAP_FLAG_DEC;
        nxt_cur.push_d = {8'h_00, flags_in};
        nxt_cur.sp_wr = 1'b1;
        nxt_cur.sp_d = cur_ff.sp_d - opd_pkg::TRAP_FLAG_DEC;
        nxt_cur.pc_ld = 1'b1;
        nxt_cur.pc_d = vector_data;
        nxt_cur.st = opd_pkg::ST_OPC;
      end
      default: begin
        nxt_cur.st = opd_pkg::ST_OPC;
      end
    endcase
  end

  // The reset branch loads constants only. The state comes up in
  // opcode wait with every pulse low, so the datapath sees no
  // spurious write while the reset is being released.
  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur_ff <= '{st: opd_pkg::ST_OPC, len: opd_pkg::LEN_1,
                  sp_d: opd_pkg::RESET_SP, pc_d: opd_pkg::RESET_PC,
                  default: '0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // The field views are slices of, or sums on, the latched bytes. They are valid
  // from the cycle after the last operand byte is taken until the
  // next opcode is accepted. Which view applies depends on the
  // opcode. Every view is driven all the time, so the datapath picks
  // the one it needs and no multiplexer is needed here.
  // Operand field views, all from latched bytes
  assign busy = cur_ff.st != opd_pkg::ST_OPC;
  assign instr_len = cur_ff.len;
  assign opcode = cur_ff.opc;
  assign bit_sel = cur_ff.b1[6:4];
  assign polarity = cur_ff.b1[0];
  assign extended_reg_operand = {cur_ff.b1[3:0], cur_ff.b2};
  assign reg_addr = cur_ff.b1;
  assign pair_addr = cur_ff.b1 & opd_pkg::PAIR_MASK;
  assign wpair_sel = cur_ff.b1[3:0] & opd_pkg::WPAIR_MASK;
  assign immediate_operand = cur_ff.b2;
  assign direct_addr_operand = {cur_ff.b1, cur_ff.b2};
  // Target counts from the byte after the whole instruction
  assign relative_target = opd_sadd(program_counter + 16'(cur_ff.len),
                                    cur_ff.b1);
  // Indexed: byte register for LEA r, pair otherwise
  assign indexed_addr = (cur_ff.opc == opd_pkg::OP_LEA_R) ?
                        opd_sadd({8'h_00, index_base}, cur_ff.b2) :
                        opd_sadd(pair_value, cur_ff.b2);
  // Carry-flag effect. Every opcode handled here leaves the carry
  // alone; the bit test changes only zero, sign and overflow.
  // Opcodes outside the set report undefined, so the datapath never
  // trusts a carry that this decoder cannot vouch for.
  assign flag_fx = (cur_ff.opc == opd_pkg::OP_TM_R_IM ||
                    cur_ff.opc == opd_pkg::OP_NOP ||
                    cur_ff.opc == opd_pkg::OP_BYTE_MULTIPLY_OP ||
                    cur_ff.opc == opd_pkg::OP_TRAP ||
                    cur_ff.opc == opd_pkg::OP_LDX_R_ER ||
                    cur_ff.opc == opd_pkg::OP_LDX_ER_ER ||
                    cur_ff.opc == opd_pkg::OP_LDX_ER_IM ||
                    cur_ff.opc == opd_pkg::OP_LDX_R_XRR ||
                    cur_ff.opc == opd_pkg::OP_LEA_R ||
                    is_block_move(cur_ff.opc)) ? opd_pkg::FX_KEEP :
                   opd_pkg::FX_UNDEF;
  assign wr_pair_en = cur_ff.wr_pair;
  assign pair_wdata = cur_ff.pair_d;
  assign wr_wreg_en = cur_ff.wr_wreg;
  assign wreg_wdata = cur_ff.wreg_d;
  assign push_en = cur_ff.push;
  assign push_addr = cur_ff.push_a;
  assign push_data = cur_ff.push_d;
  assign push_word = cur_ff.push_w;
  assign sp_wr_en = cur_ff.sp_wr;
  assign sp_wdata = cur_ff.sp_d;
  assign pc_load_en = cur_ff.pc_ld;
  assign pc_wdata = cur_ff.pc_d;
endmodule : opd_decoder

// [verif/opd_chk_asserts.sv]
/* Port checker for the operand decoder.
   Assumes it is bound to opd_decoder and reset is active high. */
`timescale 1ns/100ps
module opd_chk (
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire logic [15:0] program_counter, // Opcode address
  input wire logic [15:0] stack_pointer, // Stack top
  input wire logic [15:0] pair_value, // Pair value
  input wire logic [7:0] wreg_value, // Pointer value
  input wire logic [7:0] opcode, // Opcode
  input wire logic [2:0] instr_len, // Length
  input wire logic [7:0] reg_addr, // First byte
  input wire logic [7:0] pair_addr, // Pair address
  input wire logic [3:0] wpair_sel, // Working pair
  input wire logic [7:0] immediate_operand, // Second byte
  input wire logic [15:0] direct_addr_operand, // Address
  input wire logic [15:0] relative_target, // Branch target
  input wire logic wr_pair_en, // Pair write
  input wire logic [15:0] pair_wdata, // Pair data
  input wire logic wr_wreg_en, // Pointer write
  input wire logic [7:0] wreg_wdata, // Pointer data
  input wire logic push_en, // Push
  input wire logic [15:0] push_addr, // Push address
  input wire logic push_word, // Word push
  input wire logic pc_load_en // Vector load
);
  // One clock domain, so clock and reset are given once
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_pair_even; pair_addr == {reg_addr[7:1], 1'b0}; endproperty
  a_pair_even: assert property (p_pair_even) else $error("odd pair");
  property p_wpair; wpair_sel == {reg_addr[3:1], 1'b0}; endproperty
  a_wpair: assert property (p_wpair) else $error("odd wpair");
  property p_direct;
    direct_addr_operand == {reg_addr, immediate_operand};
  endproperty
  a_direct: assert property (p_direct) else $error("direct addr");
  // Target counts from the byte after the whole instruction
  property p_rel;
    relative_target == program_counter + 16'(instr_len)
      + {{8{reg_addr[7]}}, reg_addr};
  endproperty
  a_rel: assert property (p_rel) else $error("rel target");
  property p_byte_multiply_op;
    wr_pair_en && opcode == opd_pkg::OP_BYTE_MULTIPLY_OP |->
      pair_wdata == $past(pair_value[15:8]) * $past(pair_value[7:0]);
  endproperty
  a_byte_multiply_op: assert property (p_byte_multiply_op) else $error("product");
  property p_wreg; wr_wreg_en |-> wreg_wdata == $past(wreg_value) + 8'h_01;
  endproperty
  a_wreg: assert property (p_wreg) else $error("ptr inc");
  property p_move;
    wr_wreg_en |-> wr_pair_en && pair_wdata == $past(pair_value) + 16'h_0001;
  endproperty
  a_move: assert property (p_move) else $error("pair inc");
  // Word push below the stack top, then flags one lower with the jump
  property p_trap;
    push_en && push_word |-> push_addr == $past(stack_pointer) - 16'h_0002
      ##1 push_en && !push_word && pc_load_en
      && push_addr == $past(stack_pointer, 2) - 16'h_0003;
  endproperty
  a_trap: assert property (p_trap) else $error("trap stack");
  c_byte_multiply_op: cover property (wr_pair_en && opcode == opd_pkg::OP_BYTE_MULTIPLY_OP);
  c_move: cover property (wr_wreg_en);
  c_trap: cover property (push_en && pc_load_en);
endmodule : opd_chk
bind opd_decoder opd_chk u_chk (.*);

// [verif/opd_mem.sv]
/* Program memory model: sends one instruction's bytes on request.
   Assumes the decoder takes a byte on every valid cycle. */
`timescale 1ns/100ps
module opd_mem (
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire logic start, // Send an instruction
  input wire logic slow, // Idle cycle between bytes
  input wire logic [31:0] bytes_in, // Opcode in top byte
  input wire logic [2:0] count, // Bytes to send
  output logic fetch_valid, // Byte present
  output logic [7:0] fetch_byte // Byte
);
  logic [31:0] sh_ff;
  logic [2:0] left_ff;
  // Idle line toggles so a stale byte is never mistaken for data
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fetch_valid <= 1'b0;
      fetch_byte <= 8'h_00;
      left_ff <= 3'h_0;
      sh_ff <= 32'h_0000_0000;
    end else if (start) begin
      fetch_valid <= 1'b1;
      fetch_byte <= bytes_in[31:24];
      sh_ff <= bytes_in << 8;
      left_ff <= count - 3'h_1;
    end else if (left_ff != 3'h_0 && !(slow && fetch_valid)) begin
      fetch_valid <= 1'b1;
      fetch_byte <= sh_ff[31:24];
      sh_ff <= sh_ff << 8;
      left_ff <= left_ff - 3'h_1;
    end else begin
      fetch_valid <= 1'b0;
      fetch_byte <= ~fetch_byte;
    end
  end
endmodule : opd_mem

// [verif/tb.sv]
/* Self-checking bench for the operand decoder.
   Assumes opd_pkg, opd_decoder, opd_mem and the checker are compiled. */
`timescale 1ns/100ps
module tb;
  logic clk_sys = 1'b0, rst = 1'b1, start = 1'b0, slow = 1'b0;
  logic [31:0] bytes_in = 32'h_0000_0000;
  logic [2:0] count = 3'h_1;
  logic fetch_valid, busy, polarity, wr_pair_en, wr_wreg_en, push_en;
  logic push_word, sp_wr_en, pc_load_en;
  logic [7:0] fetch_byte, opcode, reg_addr, pair_addr, immediate_operand;
  logic [7:0] wreg_wdata, index_base = 8'h_10, wreg_value = 8'h_FF;
  logic [7:0] flags_in = 8'h_A5;
  logic [15:0] program_counter = 16'h_1000, stack_pointer = 16'h_0100;
  logic [15:0] pair_value = 16'h_FFFF, vector_data = 16'h_BEEF;
  logic [15:0] direct_addr_operand, relative_target, indexed_addr;
  logic [15:0] pair_wdata, push_addr, push_data, sp_wdata, pc_wdata;
  logic [2:0] instr_len, bit_sel, flag_fx;
  logic [3:0] wpair_sel;
  logic [11:0] extended_reg_operand;
  int num_errors = 0, checked = 0;
  opd_decoder u_dut (.*);
  opd_mem u_mem (.*);
  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  // Sends one instruction and returns at the first pulse or when idle
  task automatic issue(input logic [31:0] b, input logic [2:0] n);
    int i;
    @(posedge clk_sys);
    bytes_in <= b;
    count <= n;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    for (i = 0; i < 40; i++) begin
      @(negedge clk_sys);
      if (i > 2 && (!busy || wr_pair_en || wr_wreg_en || push_en)) break;
    end
  endtask : issue
  task automatic t_byte_multiply_op();
    @(posedge clk_sys);
    pair_value <= 16'h_FFFF;
    issue(32'h_F435_0000, 3'h_2);
    chk("byte_multiply_op_wr", wr_pair_en, 1'b1);
    chk("product", pair_wdata, 16'h_FE01);
    chk("byte_multiply_op_fx", flag_fx, 3'h_0);
    chk("pair_addr", pair_addr, 8'h_34);
    chk("wpair", wpair_sel, 4'h_4);
    chk("byte_multiply_op_len", instr_len, 3'h_2);
    chk("byte_multiply_op_op", opcode, 8'h_F4);
    chk("byte_multiply_op_idle", busy, 1'b0);
  endtask : t_byte_multiply_op
  // All four block moves, with both pointers at their wrap point
  task automatic t_move();
    logic [7:0] ops [4] = '{opd_pkg::OP_PMOVE_TO_R, opd_pkg::OP_PMOVE_TO_M,
      opd_pkg::OP_DMOVE_TO_R, opd_pkg::OP_DMOVE_TO_M};
    foreach (ops[k]) begin
      issue({ops[k], 24'h_4000_00}, 3'h_2);
      chk("mv_wr", {wr_wreg_en, wr_pair_en}, 2'h_3);
      chk("mv_ptr", wreg_wdata, 8'h_00);
      chk("mv_pair", pair_wdata, 16'h_0000);
      chk("mv_fx", flag_fx, 3'h_0);
    end
  endtask : t_move
  // Slow memory: the decoder must wait for the vector byte
  task automatic t_trap();
    @(posedge clk_sys);
    slow <= 1'b1;
    program_counter <= 16'h_1234;
    issue(32'h_F280_0000, 3'h_2);
    chk("push1", {push_en, push_word, sp_wr_en}, 3'h_7);
    chk("push1_a", push_addr, 16'h_00FE);
    chk("push1_d", push_data, 16'h_1236);
    chk("sp1", sp_wdata, 16'h_00FE);
    @(negedge clk_sys);
    chk("push2", {push_en, push_word, pc_load_en}, 3'h_5);
    chk("push2_a", push_addr, 16'h_00FD);
    chk("push2_d", push_data, 16'h_00A5);
    chk("sp", sp_wdata, 16'h_00FD);
    chk("vec", pc_wdata, 16'h_BEEF);
  endtask : t_trap
  task automatic t_fields();
    @(posedge clk_sys);
    slow <= 1'b0;
    program_counter <= 16'h_1000;
    pair_value <= 16'h_0200;
    issue(32'h_E9FA_8033, 3'h_4);
    chk("bit", bit_sel, 3'h_7);
    chk("pol0", polarity, 1'b0);
    chk("ext", extended_reg_operand, 12'h_A80);
    chk("reg", reg_addr, 8'h_FA);
    chk("imm", immediate_operand, 8'h_80);
    chk("direct", direct_addr_operand, 16'h_FA80);
    chk("rel_back", relative_target, 16'h_0FFE);
    chk("len4", instr_len, 3'h_4);
    issue(32'h_8801_8000, 3'h_3);
    chk("index", indexed_addr, 16'h_0180);
    chk("pol1", polarity, 1'b1);
    chk("rel_fwd", relative_target, 16'h_1004);
    issue(32'h_9801_F000, 3'h_3);
    chk("lea_idx", indexed_addr, 16'h_0000);
    issue(32'h_7612_3400, 3'h_3);
    chk("tm_fx", flag_fx, 3'h_0);
    chk("tm_len", instr_len, 3'h_3);
    issue(32'h_0F00_0000, 3'h_1);
    chk("nop_fx", flag_fx, 3'h_0);
    chk("nop_len", instr_len, 3'h_1);
  endtask : t_fields
  // Main sequence after five reset cycles
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_byte_multiply_op();
    t_move();
    t_trap();
    t_fields();
    conclude();
  end
  // Watchdog well beyond the fewer than a hundred cycles the tests need
  initial begin
    repeat (2000) @(posedge clk_sys);
    num_errors++;
    conclude();
  end
endmodule : tb
